/* File: hdl/ulms_pkg.sv */
// Purpose: constants for the uart line and modem status block
// Assumes: apb register map with one byte-wide register per aligned word
// Notes: offsets below are byte addresses
package ulms_pkg;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  // register byte offsets
  localparam logic [7:0] OFF_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h04;
  localparam logic [7:0] OFF_SCRATCH = 8'h08;
  localparam logic [7:0] OFF_MODEM_CONTROL = 8'h0C;
  localparam logic [7:0] OFF_ENH_FEATURE = 8'h10;
  localparam logic [7:0] OFF_FEATURE_CTRL = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFF_FIFO_CTRL = 8'h1C;
  // field positions
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  localparam int MC_OP1 = 2;
  localparam int MC_OP2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_PRESCALE = 7;
  localparam int EF_ENH = 4;
  localparam int EF_AUTO_CTS = 7;
  localparam int FC_SWAP = 6;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int XF_TX_DIS = 4;
  localparam int XF_RX_DIS = 5;
  localparam int XF_NINE = 6;
  localparam int XF_FAST_IR = 7;
  localparam int FF_EN = 0;
  // reset values
  localparam logic [7:0] SCRATCH_RST = 8'hFF;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // timing
  localparam int PRESCALE_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
  localparam int IR_SLOW_NUM = 3;
  localparam int IR_SLOW_DEN = 16;
  localparam int IR_FAST_NUM = 1;
  localparam int IR_FAST_DEN = 4;
  typedef enum logic [1:0] {CNT_RX, CNT_TX, CNT_ALT} ulms_cnt_type;
endpackage

/* File: hdl/ulms_status.sv */
// Purpose: line status, modem status and extended control of a fifo uart
// Assumes: receiver/transmitter cores report events as one-cycle pulses
// Notes: apb slave, zero wait states; one byte per aligned word
// Functional notes
// - prescaler divides clock by four when enabled
// - overrun interrupts immediately; errors at head
// - data ready while any character held
// - overrun when full; fifo left intact
// - parity error belongs to head character
// - framing error belongs to head character
// - break loads one character, held till idle
// - holding empty tracks register or fifo
// - transmitter empty when holding and shifter empty
// - fifo error summary while errored character present
// - input changes set delta bits, modem interrupt
// - ring change only on rising input
// - auto flow pauses transmit while input high
// - upper bits inverted pins or loopback outputs
// - extended write disables transmitter or receiver
// - bit six selects nine-bit multidrop
// - bit seven selects infrared pulse width
// - scratch register resets to all ones
// - swap sends scratch writes to mode register
// - mode bits select counter readback
// - alternating mode starts with receive level
// - swap reads return fifo level
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
module ulms_status #(
  parameter int DEPTH = ulms_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ulms_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxCharDone,
  input wire logic [7:0] rxCharData,
  input wire logic rxParityBad,
  input wire logic rxFrameBad,
  input wire logic rxLineLow,
  input wire logic rxPop,
  input wire logic txPush,
  input wire logic txShiftLoad,
  input wire logic txShiftDone,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ring_indicator_in_n,
  input wire logic carrier_detect_in_n,
  output logic [7:0] rxHeadData,
  output logic baudClkEn,
  output logic txAllowed,
  output logic rxEnable,
  output logic nineBitMode,
  output logic fastIrMode,
  output logic [4:0] irPulseSixteenths,
  output logic lineIrq,
  output logic modemIrq,
  output logic rts_n,
  output logic dtr_n
);
  import ulms_pkg::*;

  function automatic logic [CNT_W-1:0] incDec(input logic [CNT_W-1:0] c, input logic up,
                                               input logic dn);
    incDec = c + CNT_W'(up) - CNT_W'(dn);
  endfunction

  // apb decode
  wire logic access = psel && penable;
  wire logic wrEn = access && pwrite;
  wire logic rdEn = access && !pwrite;
  wire logic hitLs = paddr == OFF_LINE_STATUS;
  wire logic hitMs = paddr == OFF_MODEM_STATUS;
  wire logic hitSp = paddr == OFF_SCRATCH;
  wire logic hitMc = paddr == OFF_MODEM_CONTROL;
  wire logic hitEf = paddr == OFF_ENH_FEATURE;
  wire logic hitFc = paddr == OFF_FEATURE_CTRL;
  wire logic hitIe = paddr == OFF_IRQ_ENABLE;
  wire logic hitFf = paddr == OFF_FIFO_CTRL;
  wire logic mapped = hitLs | hitMs | hitSp | hitMc | hitEf | hitFc | hitIe | hitFf;
  wire logic [7:0] wb = pwdata[7:0];

  logic [7:0] mcr_q, efr_q, feature_control_q, ier_q, fcr_q, xfw_q, spr_q, enhanced_mode_select_q;
  wire logic enh = efr_q[EF_ENH];
  wire logic fifoOn = fcr_q[FF_EN];
  wire logic loopOn = mcr_q[MC_LOOP];
  wire logic swapOn = feature_control_q[FC_SWAP];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mcr_q <= ZERO_RST;
      efr_q <= ZERO_RST;
      feature_control_q <= ZERO_RST;
      ier_q <= ZERO_RST;
      fcr_q <= ZERO_RST;
      xfw_q <= ZERO_RST;
      spr_q <= SCRATCH_RST;
      enhanced_mode_select_q <= ZERO_RST;
    end else if (wrEn) begin
      if (hitMc) mcr_q <= wb;
      if (hitEf) efr_q <= wb;
      if (hitFc) feature_control_q <= wb;
      if (hitIe) ier_q <= wb;
      if (hitFf) fcr_q <= wb;
      if (hitMs && enh) xfw_q <= wb;
      if (hitSp && !swapOn) spr_q <= wb;
      if (hitSp && swapOn) enhanced_mode_select_q <= wb;
    end
  end

  // prescaler: enable pulse every fourth clock when selected
  logic [1:0] pre_q;
  wire logic preSel = mcr_q[MC_PRESCALE] && enh;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pre_q <= 2'h0;
    else pre_q <= (pre_q == PRESCALE_LAST) ? 2'h0 : pre_q + 2'h1;
  end

  // receive fifo with per-character error tags
  logic [7:0] rxMem [DEPTH];
  logic [2:0] tagMem [DEPTH];
  logic [CNT_W-2:0] rxWr_q, rxRd_q;
  logic [CNT_W-1:0] rxCnt_q, txCnt_q, errCnt_q;
  logic ovr_q, brkHeld_q, holdFull_q, shiftBusy_q;
  wire logic rxFull = fifoOn ? (rxCnt_q == CNT_W'(DEPTH)) : (rxCnt_q != 6'h00);
  wire logic rxOn = !(xfw_q[XF_RX_DIS] && enh);
  // break is only loaded once per low period
  wire logic brkChar = rxCharDone && rxLineLow;
  wire logic takeChar = rxCharDone && rxOn && !rxFull && !(brkChar && brkHeld_q);
  wire logic ovrEv = rxCharDone && rxOn && rxFull;
  wire logic popOk = rxPop && (rxCnt_q != 6'h00);
  wire logic [2:0] inTag = {brkChar, rxFrameBad, rxParityBad};
  wire logic [2:0] headTag = (rxCnt_q != 6'h00) ? tagMem[rxRd_q] : 3'h0;
  wire logic inErr = takeChar && (inTag != 3'h0);
  wire logic outErr = popOk && (headTag != 3'h0);

  always_ff @(posedge clk) begin
    if (takeChar) begin
      rxMem[rxWr_q] <= rxCharData;
      tagMem[rxWr_q] <= inTag;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxWr_q <= '0;
      rxRd_q <= '0;
      rxCnt_q <= '0;
      errCnt_q <= '0;
      brkHeld_q <= 1'b0;
    end else begin
      if (takeChar) rxWr_q <= rxWr_q + 1'b1;
      if (popOk) rxRd_q <= rxRd_q + 1'b1;
      rxCnt_q <= incDec(rxCnt_q, takeChar, popOk);
      errCnt_q <= incDec(errCnt_q, inErr, outErr);
      brkHeld_q <= rxLineLow && (brkHeld_q || brkChar);
    end
  end

  // transmit side occupancy
  wire logic txOn = !(xfw_q[XF_TX_DIS] && enh);
  wire logic txCap = fifoOn ? (txCnt_q != CNT_W'(DEPTH)) : (txCnt_q == 6'h00);
  wire logic pushOk = txPush && txCap;
  wire logic loadOk = txShiftLoad && (txCnt_q != 6'h00);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txCnt_q <= '0;
      shiftBusy_q <= 1'b0;
    end else begin
      txCnt_q <= incDec(txCnt_q, pushOk, loadOk);
      if (loadOk) shiftBusy_q <= 1'b1;
      else if (txShiftDone) shiftBusy_q <= 1'b0;
    end
  end

  // line status assembly
  wire logic rxErrNow = ovrEv;
  wire logic msRead = rdEn && hitMs;
  wire logic lsRead = rdEn && hitLs;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ovr_q <= 1'b0;
    else ovr_q <= rxErrNow || (ovr_q && !lsRead);
  end
  wire logic thrEmpty = txCnt_q == 6'h00;
  wire logic txIdle = thrEmpty && !shiftBusy_q;
  wire logic [7:0] lineStatus = {errCnt_q != 6'h00, txIdle, thrEmpty, headTag,
                                 ovr_q, rxCnt_q != 6'h00};

  // modem inputs: three-flop sync, change accepted when stages two and three agree
  logic [3:0] s1_q, s2_q, s3_q, pin_q, delta_q;
  wire logic [3:0] pinsRaw = {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n};
  wire logic [3:0] loopVal = ~{mcr_q[MC_OP2], mcr_q[MC_OP1], mcr_q[MC_DTR], mcr_q[MC_RTS]};
  wire logic [3:0] agreed = (s2_q == s3_q) ? s3_q : pin_q;
  wire logic [3:0] effN = loopOn ? loopVal : agreed;
  wire logic [3:0] chg = effN ^ pin_q;
  // ring flag: input low-to-high only
  wire logic [3:0] deltaEv = {chg[3], chg[2] & effN[2], chg[1], chg[0]};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      s3_q <= 4'hF;
      pin_q <= 4'hF;
      delta_q <= 4'h0;
    end else begin
      s1_q <= pinsRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= effN;
      delta_q <= deltaEv | (delta_q & {4{!msRead}});
    end
  end
  wire logic [7:0] modemStatus = {~pin_q, delta_q};

  // fifo level readback
  logic altTx_q;
  wire logic [1:0] cm = enhanced_mode_select_q[1:0];
  wire ulms_cnt_type cntMode = !cm[0] ? CNT_RX : (cm[1] ? CNT_ALT : CNT_TX);
  wire logic spRead = rdEn && hitSp && swapOn;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) altTx_q <= 1'b0;
    else if (wrEn && hitSp && swapOn) altTx_q <= 1'b0;
    else if (spRead && cntMode == CNT_ALT) altTx_q <= !altTx_q;
  end
  logic [CNT_W-1:0] lvl;
  always_comb begin
    case (cntMode)
      CNT_RX: lvl = rxCnt_q;
      CNT_TX: lvl = txCnt_q;
      CNT_ALT: lvl = altTx_q ? txCnt_q : rxCnt_q;
      default: lvl = rxCnt_q;
    endcase
  end
  wire logic [7:0] spVal = swapOn ? {2'h0, lvl} : spr_q;

  wire logic [7:0] rdByte = ({8{hitLs}} & lineStatus) | ({8{hitMs}} & modemStatus) |
                            ({8{hitSp}} & spVal) | ({8{hitMc}} & mcr_q) |
                            ({8{hitEf}} & efr_q) | ({8{hitFc}} & feature_control_q) |
                            ({8{hitIe}} & ier_q) | ({8{hitFf}} & fcr_q);

  // interrupts: overrun at once, other errors only at the head
  wire logic lineSrc = ovr_q || (headTag != 3'h0);
  wire logic autoCts = efr_q[EF_AUTO_CTS];
  // pin_q holds the pin level, so a high clear-to-send pin pauses
  wire logic ctsPause = autoCts && pin_q[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rxHeadData <= 8'h00;
      baudClkEn <= 1'b0;
      txAllowed <= 1'b0;
      rxEnable <= 1'b1;
      nineBitMode <= 1'b0;
      fastIrMode <= 1'b0;
      irPulseSixteenths <= 5'h03;
      lineIrq <= 1'b0;
      modemIrq <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? {24'h0, rdByte} : prdata;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      rxHeadData <= (rxCnt_q != 6'h00) ? rxMem[rxRd_q] : 8'h00;
      baudClkEn <= !preSel || (pre_q == PRESCALE_LAST);
      // hold off after the current character, not mid-frame
      txAllowed <= txOn && !(ctsPause && !shiftBusy_q);
      rxEnable <= rxOn;
      nineBitMode <= xfw_q[XF_NINE];
      fastIrMode <= xfw_q[XF_FAST_IR];
      irPulseSixteenths <= xfw_q[XF_FAST_IR] ? 5'(IR_FAST_NUM * IR_SLOW_DEN / IR_FAST_DEN) :
                           5'(IR_SLOW_NUM);
      lineIrq <= ier_q[IE_LINE] && lineSrc;
      modemIrq <= ier_q[IE_MODEM] && (delta_q != 4'h0);
      rts_n <= loopOn ? 1'b1 : !mcr_q[MC_RTS];
      dtr_n <= loopOn ? 1'b1 : !mcr_q[MC_DTR];
    end
  end
endmodule

/* File: bench/ulms_modem_model.sv */
// Purpose: remote modem driving the modem status inputs
// Assumes: pins move just after a clock edge
// Notes: slow adds one cycle of lag; idle level is high
`timescale 1ns/10ps
module ulms_modem_model (
  input wire logic clk,
  input wire logic [3:0] want,
  input wire logic slow,
  output logic cts_n,
  output logic dsr_n,
  output logic ring_indicator_in_n,
  output logic carrier_detect_in_n
);
  logic [3:0] lag_q = 4'hF;
  logic [3:0] pin_q = 4'hF;
  always_ff @(posedge clk) begin
    lag_q <= want;
    pin_q <= slow ? lag_q : want;
  end
  assign {carrier_detect_in_n, ring_indicator_in_n, dsr_n, cts_n} = pin_q;
endmodule

/* File: bench/ulms_status_props.sv */
// Purpose: port-level checks of the uart status block
// Assumes: one clock, apb access cycle marks writes
// Notes: bound into every instance of the top module
`timescale 1ns/10ps
module ulms_status_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ulms_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rxCharDone,
  input wire logic rxPop,
  input wire logic baudClkEn,
  input wire logic rxEnable,
  input wire logic nineBitMode,
  input wire logic fastIrMode,
  input wire logic [4:0] irPulseSixteenths,
  input wire logic lineIrq,
  input wire logic modemIrq,
  input wire logic rts_n
);
  import ulms_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable;
  wire wrAcc = acc && pwrite;
  wire xfWr = wrAcc && paddr == OFF_MODEM_STATUS;
  wire cause = rxCharDone || rxPop || wrAcc;
  chk_baud_gap: assert property (!baudClkEn |-> ##[1:3] baudClkEn)
    else $error("baud enable missing");
  chk_ir_width: assert property (irPulseSixteenths == (fastIrMode ? 5'h4 : 5'h3))
    else $error("ir pulse width wrong");
  chk_rx_disable: assert property ($changed(rxEnable) |->
    $past(xfWr, 2) && rxEnable == !$past(pwdata[XF_RX_DIS], 2)) else $error("rx enable wrong");
  chk_nine_bit: assert property ($changed(nineBitMode) |->
    $past(xfWr, 2) && nineBitMode == $past(pwdata[XF_NINE], 2)) else $error("nine bit wrong");
  chk_fast_ir: assert property ($changed(fastIrMode) |->
    $past(xfWr, 2) && fastIrMode == $past(pwdata[XF_FAST_IR], 2)) else $error("fast ir wrong");
  chk_rts_write: assert property ($changed(rts_n) |-> $past(wrAcc, 2))
    else $error("rts moved without a write");
  chk_line_cause: assert property ($rose(lineIrq) |-> $past(cause) || $past(cause, 2))
    else $error("line irq without cause");
  chk_modem_clear: assert property ($fell(modemIrq) |-> $past(acc) || $past(acc, 2))
    else $error("modem irq dropped without access");
  cover property (xfWr);
  cover property ($rose(lineIrq));
  cover property ($fell(modemIrq));
endmodule
bind ulms_status ulms_status_props i_props (.*);

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the uart status block
// Assumes: zero wait state apb, event pulses of one cycle
// Notes: break line driven during the receive fill
`timescale 1ns/10ps
module testbench;
  import ulms_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, err;
  logic brk = 0, bh = 0;
  logic [7:0] paddr = 0, rxCharData = 0, rxHeadData, r, x, sp;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, rxCharDone = 0, rxParityBad = 0, rxFrameBad = 0;
  logic [3:0] ev = 0, want = 4'hF, w, o, d;
  logic ctsN, dsrN, riN, cdN, baudClkEn, txAllowed, rxEnable, nineBitMode, fastIrMode;
  logic lineIrq, modemIrq, rts_n, dtr_n;
  logic [4:0] irPulseSixteenths;
  int failures = 0, comparisons = 0, cyc = 0, n, txn = 0, sh = 0, ovr = 0;
  int rxq[$];
  initial forever #4 clk = ~clk;
  ulms_modem_model i_modem (.clk(clk), .want(want), .slow(slow), .cts_n(ctsN), .dsr_n(dsrN),
    .ring_indicator_in_n(riN), .carrier_detect_in_n(cdN));
  ulms_status i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxCharDone(rxCharDone), .rxCharData(rxCharData),
    .rxParityBad(rxParityBad), .rxFrameBad(rxFrameBad), .rxLineLow(brk), .rxPop(ev[3]),
    .txPush(ev[0]), .txShiftLoad(ev[1]), .txShiftDone(ev[2]), .cts_n(ctsN), .dsr_n(dsrN),
    .ring_indicator_in_n(riN), .carrier_detect_in_n(cdN), .rxHeadData(rxHeadData),
    .baudClkEn(baudClkEn), .txAllowed(txAllowed), .rxEnable(rxEnable),
    .nineBitMode(nineBitMode), .fastIrMode(fastIrMode),
    .irPulseSixteenths(irPulseSixteenths), .lineIrq(lineIrq), .modemIrq(modemIrq),
    .rts_n(rts_n), .dtr_n(dtr_n));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      summarize();
    end
  end
  // request held until pready is seen at a rising edge
  task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] v);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1);
    r = prdata[7:0];
    err = pslverr;
    psel <= 0; penable <= 0;
    // two more edges so registered outputs have settled
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(a, 0, 8'h00);
    chk(r, e);
  endtask
  function automatic logic [7:0] line_status();
    logic [7:0] e;
    e = 8'h00;
    foreach (rxq[i]) if (rxq[i][10:8] != 0) e[7] = 1;
    if (rxq.size() > 0) e[4:0] = {rxq[0][10], rxq[0][9], rxq[0][8], 2'b01};
    e[1] = ovr[0]; e[5] = txn == 0; e[6] = txn == 0 && sh == 0;
    return e;
  endfunction
  task automatic chkLsr();
    rd(OFF_LINE_STATUS, line_status());
    ovr = 0;
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask
  task automatic rxc();
    logic p, f;
    p = ($urandom % 4) == 0; f = ($urandom % 4) == 0; x = 8'($urandom);
    rxCharData <= x; rxParityBad <= p; rxFrameBad <= f; rxCharDone <= 1;
    @(posedge clk);
    rxCharDone <= 0;
    @(posedge clk);
    // only one break character per low period
    if (!(brk && bh) && rxq.size() < FIFO_DEPTH) rxq.push_back({brk, f, p, x});
    else if (!(brk && bh)) ovr = 1;
    bh = brk;
  endtask
  initial begin
    void'($urandom(30));
    repeat (10) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    rd(OFF_SCRATCH, 8'hFF);
    rd(OFF_LINE_STATUS, 8'h60);
    rd(8'h20, 8'h00);
    chk(err, 1'b1);
    sp = 8'($urandom);
    apb(OFF_SCRATCH, 1, sp);
    rd(OFF_SCRATCH, sp);
    apb(OFF_MODEM_STATUS, 0, 8'h00);
    apb(OFF_ENH_FEATURE, 1, 8'h10);
    apb(OFF_FIFO_CTRL, 1, 8'h01);
    apb(OFF_IRQ_ENABLE, 1, 8'h0C);
    $display("end of reset test");
    brk <= 1;
    rxc(); rxc();
    brk <= 0; bh = 0;
    repeat (FIFO_DEPTH + 1) rxc();
    @(posedge clk);
    chk(lineIrq, 1'b1);
    chkLsr();
    while (rxq.size() > 0) begin
      chkLsr();
      chk(rxHeadData, rxq[0][7:0]);
      pulse(3);
      void'(rxq.pop_front());
    end
    chkLsr();
    $display("end of receive test");
    apb(OFF_FEATURE_CTRL, 1, 8'h40);
    apb(OFF_SCRATCH, 1, 8'h01);
    repeat (3) begin pulse(0); txn++; end
    chkLsr();
    rd(OFF_SCRATCH, 8'h03);
    rxc(); rxc();
    apb(OFF_SCRATCH, 1, 8'h02);
    rd(OFF_SCRATCH, 8'h02);
    apb(OFF_SCRATCH, 1, 8'h03);
    for (int i = 0; i < 4; i++) rd(OFF_SCRATCH, i[0] ? 8'h03 : 8'h02);
    repeat (3) begin
      pulse(1); txn--; sh = 1;
      chkLsr();
      pulse(2); sh = 0;
      chkLsr();
    end
    apb(OFF_FEATURE_CTRL, 1, 8'h00);
    rd(OFF_SCRATCH, sp);
    $display("end of transmit and swap test");
    for (int i = 0; i < 8; i++) begin
      o = want; w = 4'($urandom);
      want <= w; slow <= i[0];
      repeat (10) @(posedge clk);
      d = w ^ o; d[2] = w[2] & ~o[2];
      chk(modemIrq, |d);
      rd(OFF_MODEM_STATUS, {~w, d});
    end
    for (int i = 0; i < 16; i++) begin
      apb(OFF_MODEM_CONTROL, 1, 8'(16 + i));
      repeat (6) @(posedge clk);
      apb(OFF_MODEM_STATUS, 0, 8'h00);
      chk(r[7:4], {i[3], i[2], i[0], i[1]});
      chk({rts_n, dtr_n}, 2'b11);
    end
    apb(OFF_MODEM_CONTROL, 1, 8'h03);
    chk({rts_n, dtr_n}, 2'b00);
    $display("end of modem test");
    repeat (4) begin
      x = 8'($urandom);
      apb(OFF_MODEM_STATUS, 1, x & 8'hF0);
      chk({txAllowed, rxEnable, nineBitMode, fastIrMode}, {~x[4], ~x[5], x[6], x[7]});
      chk(irPulseSixteenths, x[7] ? 5'h04 : 5'h03);
    end
    apb(OFF_MODEM_STATUS, 1, 8'h00);
    apb(OFF_ENH_FEATURE, 1, 8'h90);
    for (int i = 0; i < 2; i++) begin
      want <= {want[3:1], ~i[0]};
      repeat (10) @(posedge clk);
      chk(txAllowed, i[0]);
    end
    for (int i = 0; i < 2; i++) begin
      apb(OFF_MODEM_CONTROL, 1, i[0] ? 8'h00 : 8'h80);
      n = 0;
      repeat (40) begin @(posedge clk); n += baudClkEn; end
      chk(n, i[0] ? 40 : 10);
    end
    $display("end of control test");
    summarize();
  end
endmodule
